// File: led_string_pkg.sv
// shared constants and types for the led string boost controller
package led_string_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] STRING_REF_OFFSET = 8'h20;
    localparam logic [7:0] BOOST_REF_OFFSET = 8'h21;
    localparam logic [7:0] STRING_REF_RESET = 8'h64;
    localparam logic [7:0] BOOST_REF_RESET = 8'h64;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLOCK_HZ = 25000000;
    localparam int POWERUP_MS = 6;
    localparam int OPTIMISE_MS = 250;
    localparam int MIN_ON_NS = 2000;
    localparam int CLOCK_NS = 40;
    localparam int POWERUP_CYCLES = POWERUP_MS * (CLOCK_HZ / 1000);
    localparam int OPTIMISE_CYCLES = OPTIMISE_MS * (CLOCK_HZ / 1000);
    localparam int MIN_ON_CYCLES = (MIN_ON_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int OFF_TIME_DEFAULT = 110;
    localparam logic [7:0] TRIM_MAX = 8'hFF;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_POWERUP = 4'b0010,
        ST_OPTIMISE = 4'b0100,
        ST_RUN = 4'b1000
    } seq_state_type;

    // register write port
    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_type;

    // comparator results from the analog front end
    typedef struct packed {
        logic boost_peak;
        logic string_low;
        logic string_out_of_reg;
    } sense_type;

endpackage

// File: boost_off_timer.sv
// constant off-time boost switch gate control
`timescale 1ns/100ps

module boost_off_timer #(
    parameter int OFF_CYCLES = led_string_pkg::OFF_TIME_DEFAULT
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // control
    input wire logic run_i,
    input wire logic peak_i,
    // gate
    output logic gate_o
);

    logic gate_q;
    logic gate_d;
    logic [15:0] off_cnt_q;
    logic [15:0] off_cnt_d;

    always_comb begin
        gate_d = gate_q;
        off_cnt_d = off_cnt_q;
        if (!run_i) begin
            gate_d = 1'b0;
            off_cnt_d = 16'h0000;
        end else if (gate_q) begin
            if (peak_i) begin
                gate_d = 1'b0;
                off_cnt_d = 16'(OFF_CYCLES);
            end
        end else if (off_cnt_q > 16'h0001) begin
            off_cnt_d = off_cnt_q - 16'h0001;
        end else begin
            off_cnt_d = 16'h0000;
            gate_d = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gate_q <= 1'b0;
            off_cnt_q <= 16'h0000;
        end else begin
            gate_q <= gate_d;
            off_cnt_q <= off_cnt_d;
        end
    end

    assign gate_o = gate_q;

    chk_off_time_held: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (run_i && gate_q && peak_i) |=> !gate_q [*2])
        else $error("boost gate reopened too early");
    chk_off_count_load: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (run_i && gate_q && peak_i) |=> off_cnt_q == 16'(OFF_CYCLES))
        else $error("boost off time not loaded at peak");
    chk_peak_turns_off: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (gate_q && peak_i) |=> !gate_q)
        else $error("boost gate not turned off at peak");

endmodule // boost_off_timer

// File: led_string_boost_control.sv
// sequencer, string gate and reference registers of the led string driver
`timescale 1ns/100ps

// Contract
// - after enable rises the string stays off for a 6 ms power-up delay.
// - then a roughly 250 ms optimisation runs before the string follows the dimming input.
// - the boost gate turns off three clocks after the peak comparator trips: two synchroniser stages, then the gate register.
// - after a peak event the boost gate stays off for exactly the programmed off-time.
// - the boost peak reference register at 0x21 sets the threshold and resets to 0x64.
// - the string reference register at 0x20 sets the source-sense target at 2 mV per step.
// - out of reset the string target is 0.2 V and the string current is regulated to it.
// - while running the string gate follows the dimming input in frequency and duty.
// - every string gate on period lasts at least 2 us, unless enable low or over-temperature ends the run first.
// - the optimiser adjusts its feedback sink to keep the string just in regulation.
// - the string loop watches the source sense and adjusts the string gate drive.
// - over-temperature shuts down and recovery repeats the full turn-on sequence.
// - enable low restores the register defaults for the next turn-on.
module led_string_boost_control #(
    parameter int POWERUP_CYCLES = led_string_pkg::POWERUP_CYCLES,
    parameter int OPTIMISE_CYCLES = led_string_pkg::OPTIMISE_CYCLES,
    parameter int OFF_CYCLES = led_string_pkg::OFF_TIME_DEFAULT
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // pins from outside
    input wire logic enable_i,
    input wire logic dimming_i,
    input wire logic over_temp_i,
    input wire led_string_pkg::sense_type sense_i,
    // register write port
    input wire led_string_pkg::reg_write_type reg_i,
    // outputs
    output logic string_gate_o,
    output logic boost_switch_gate_o,
    output logic [7:0] optimiser_feedback_sink_o,
    output logic [7:0] string_current_reference_o,
    output logic [7:0] boost_peak_current_reference_o,
    output logic [7:0] string_drive_o,
    output logic running_o
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic en_s, dim_s, hot_s, peak_s, low_s, oor_s;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
        end else begin
            sync1_q <= {enable_i, dimming_i, over_temp_i, sense_i.boost_peak,
                        sense_i.string_low, sense_i.string_out_of_reg};
            sync2_q <= sync1_q;
        end
    end

    assign {en_s, dim_s, hot_s, peak_s, low_s, oor_s} = sync2_q;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    led_string_pkg::seq_state_type state_q, state_d;
    logic [23:0] seq_cnt_q, seq_cnt_d;
    logic go;

    assign go = en_s && !hot_s;

    always_comb begin
        state_d = state_q;
        seq_cnt_d = seq_cnt_q;
        case (state_q)
            led_string_pkg::ST_IDLE: begin
                seq_cnt_d = 24'h000000;
                if (go) begin
                    state_d = led_string_pkg::ST_POWERUP;
                end
            end
            led_string_pkg::ST_POWERUP: begin
                if (!go) begin
                    state_d = led_string_pkg::ST_IDLE;
                end else if (seq_cnt_q == 24'(POWERUP_CYCLES - 1)) begin
                    seq_cnt_d = 24'h000000;
                    state_d = led_string_pkg::ST_OPTIMISE;
                end else begin
                    seq_cnt_d = seq_cnt_q + 24'h000001;
                end
            end
            led_string_pkg::ST_OPTIMISE: begin
                if (!go) begin
                    state_d = led_string_pkg::ST_IDLE;
                end else if (seq_cnt_q == 24'(OPTIMISE_CYCLES - 1)) begin
                    seq_cnt_d = 24'h000000;
                    state_d = led_string_pkg::ST_RUN;
                end else begin
                    seq_cnt_d = seq_cnt_q + 24'h000001;
                end
            end
            led_string_pkg::ST_RUN: begin
                if (!go) begin
                    state_d = led_string_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = led_string_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= led_string_pkg::ST_IDLE;
            seq_cnt_q <= 24'h000000;
        end else begin
            state_q <= state_d;
            seq_cnt_q <= seq_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // reference registers
    // ------------------------------------------------------------
    logic [7:0] str_ref_q, str_ref_d, cref_q, cref_d;

    always_comb begin
        str_ref_d = str_ref_q;
        cref_d = cref_q;
        if (!en_s) begin
            str_ref_d = led_string_pkg::STRING_REF_RESET;
            cref_d = led_string_pkg::BOOST_REF_RESET;
        end else if (reg_i.write) begin
            if (reg_i.addr == led_string_pkg::STRING_REF_OFFSET) begin
                str_ref_d = reg_i.data;
            end
            if (reg_i.addr == led_string_pkg::BOOST_REF_OFFSET) begin
                cref_d = reg_i.data;
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            str_ref_q <= led_string_pkg::STRING_REF_RESET;
            cref_q <= led_string_pkg::BOOST_REF_RESET;
        end else begin
            str_ref_q <= str_ref_d;
            cref_q <= cref_d;
        end
    end

    // ------------------------------------------------------------
    // string gate with minimum on-time
    // ------------------------------------------------------------
    logic gate_q, gate_d;
    logic [7:0] on_cnt_q, on_cnt_d;
    logic run;

    assign run = (state_q == led_string_pkg::ST_RUN);

    always_comb begin
        gate_d = gate_q;
        on_cnt_d = on_cnt_q;
        if (!run) begin
            gate_d = 1'b0;
            on_cnt_d = 8'h00;
        end else if (!gate_q) begin
            if (dim_s) begin
                gate_d = 1'b1;
                on_cnt_d = 8'h01;
            end
        end else begin
            if (on_cnt_q < 8'(led_string_pkg::MIN_ON_CYCLES)) begin
                on_cnt_d = on_cnt_q + 8'h01;
            end
            if (!dim_s && on_cnt_q >= 8'(led_string_pkg::MIN_ON_CYCLES)) begin
                gate_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gate_q <= 1'b0;
            on_cnt_q <= 8'h00;
        end else begin
            gate_q <= gate_d;
            on_cnt_q <= on_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // string drive and optimiser trim loops
    // ------------------------------------------------------------
    logic [7:0] drive_q, drive_d, trim_q, trim_d;
    logic active;

    assign active = (state_q == led_string_pkg::ST_OPTIMISE) || run;

    always_comb begin
        drive_d = drive_q;
        trim_d = trim_q;
        if (!active) begin
            drive_d = 8'h00;
            trim_d = 8'h00;
        end else begin
            if (low_s && drive_q != 8'hFF) begin
                drive_d = drive_q + 8'h01;
            end else if (!low_s && drive_q != 8'h00) begin
                drive_d = drive_q - 8'h01;
            end
            if (oor_s && trim_q != led_string_pkg::TRIM_MAX) begin
                trim_d = trim_q + 8'h01;
            end else if (!oor_s && trim_q != 8'h00) begin
                trim_d = trim_q - 8'h01;
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            drive_q <= 8'h00;
            trim_q <= 8'h00;
        end else begin
            drive_q <= drive_d;
            trim_q <= trim_d;
        end
    end

    // ------------------------------------------------------------
    // boost switch
    // ------------------------------------------------------------
    logic boost_gate;
    logic running_q;

    boost_off_timer #(
        .OFF_CYCLES(OFF_CYCLES)
    ) u_boost (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .run_i(active),
        .peak_i(peak_s),
        .gate_o(boost_gate)
    );

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            running_q <= 1'b0;
        end else begin
            running_q <= run;
        end
    end

    assign string_gate_o = gate_q;
    assign boost_switch_gate_o = boost_gate;
    assign optimiser_feedback_sink_o = trim_q;
    assign string_current_reference_o = str_ref_q;
    assign boost_peak_current_reference_o = cref_q;
    assign string_drive_o = drive_q;
    assign running_o = running_q;

    chk_min_on_time: assert property (@(posedge clock_i) disable iff (!nrst_i)
        $rose(gate_q) |=> gate_q [*8])
        else $error("string gate on period too short");
    chk_min_on_count: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (run && go && gate_q && on_cnt_q < 8'(led_string_pkg::MIN_ON_CYCLES)) |=> gate_q)
        else $error("string gate dropped before minimum on-time");
    chk_gate_off_idle: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !run |=> !gate_q)
        else $error("string gate on outside run");
    chk_abort_sequence: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (state_q == led_string_pkg::ST_POWERUP && !go) |=>
        state_q == led_string_pkg::ST_IDLE)
        else $error("sequence not aborted");
    chk_powerup_to_opt: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (state_q == led_string_pkg::ST_OPTIMISE && $past(state_q) !=
        led_string_pkg::ST_OPTIMISE) |-> $past(seq_cnt_q) == 24'(POWERUP_CYCLES - 1))
        else $error("power-up delay wrong");
    chk_opt_to_run: assert property (@(posedge clock_i) disable iff (!nrst_i)
        $rose(run) |-> $past(seq_cnt_q) == 24'(OPTIMISE_CYCLES - 1))
        else $error("optimise time wrong");
    chk_gate_follows: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (run && !gate_q && dim_s && go) |=> gate_q)
        else $error("string gate missed dimming edge");
    chk_stretch_end: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (run && go && gate_q && !dim_s && on_cnt_q >= 8'(led_string_pkg::MIN_ON_CYCLES))
        |=> !gate_q)
        else $error("string gate late off");
    chk_defaults_back: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !en_s |=> str_ref_q == led_string_pkg::STRING_REF_RESET &&
        cref_q == led_string_pkg::BOOST_REF_RESET)
        else $error("defaults not restored");
    chk_boost_off_idle: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !active |=> !boost_gate)
        else $error("boost gate on while stopped");

endmodule // led_string_boost_control

// File: led_power_stage.sv
// behavioural power stage: boost inductor and led string sense comparators
`timescale 1ns/100ps

module led_power_stage #(
    parameter int HEADROOM = 60
) (
    // clock
    input wire logic clock_i,
    // drive from the controller
    input wire logic boost_switch_gate_i,
    input wire logic [7:0] string_drive_i,
    input wire logic [7:0] boost_peak_current_reference_i,
    input wire logic [7:0] string_current_reference_i,
    input wire logic [7:0] optimiser_feedback_sink_i,
    // comparator results
    output led_string_pkg::sense_type sense_o
);
    // ------------------------------------------------------------
    // inductor current, emptied during the off time
    // ------------------------------------------------------------
    int current_q = 0;

    always @(posedge clock_i) begin
        if (boost_switch_gate_i === 1'b1) begin
            current_q <= current_q + 16;
        end else begin
            current_q <= 0;
        end
    end

    // ------------------------------------------------------------
    // sense comparators
    // ------------------------------------------------------------
    assign sense_o.boost_peak = current_q >= int'(boost_peak_current_reference_i);
    assign sense_o.string_low = string_drive_i < string_current_reference_i;
    // string short of headroom while the feedback sink code is below the need
    assign sense_o.string_out_of_reg = int'(optimiser_feedback_sink_i) < HEADROOM;
endmodule // led_power_stage

// File: led_string_boost_control_tb_top.sv
// self-checking bench for the led string boost controller
`timescale 1ns/100ps

`define CHK(name, exp, got) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("[FAIL] %s expected %0h seen %0h", name, exp, got); \
    end \
end

module led_string_boost_control_tb_top;
    // ------------------------------------------------------------
    // parameters and signals
    // ------------------------------------------------------------
    localparam int P = 20;
    localparam int O = 40;
    localparam int OFF = 5;
    localparam int MIN = led_string_pkg::MIN_ON_CYCLES;
    localparam int H = 60;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic enable_i = 1'b0;
    logic dimming_i = 1'b0;
    logic over_temp_i = 1'b0;
    led_string_pkg::sense_type sense;
    led_string_pkg::reg_write_type reg_w = '0;
    logic string_gate_o;
    logic boost_switch_gate_o;
    logic [7:0] optimiser_feedback_sink_o;
    logic [7:0] string_current_reference_o;
    logic [7:0] boost_peak_current_reference_o;
    logic [7:0] string_drive_o;
    logic running_o;
    int n_mismatch = 0;
    int comparisons = 0;
    int ref_model[2] = '{100, 100};
    int exp_q[$];
    int gate_len = 0;
    int b_low = 0;
    int b_high = 0;
    bit b_watch = 0;
    int i;
    int w;
    int w_mon;
    int lo_drv;
    int hi_drv;
    int lo_trim;
    int hi_trim;

    always #20 clock_i = ~clock_i;

    led_string_boost_control #(.POWERUP_CYCLES(P), .OPTIMISE_CYCLES(O), .OFF_CYCLES(OFF)) DUT (
        .clock_i(clock_i), .nrst_i(nrst_i), .enable_i(enable_i), .dimming_i(dimming_i),
        .over_temp_i(over_temp_i), .sense_i(sense), .reg_i(reg_w),
        .string_gate_o(string_gate_o), .boost_switch_gate_o(boost_switch_gate_o),
        .optimiser_feedback_sink_o(optimiser_feedback_sink_o),
        .string_current_reference_o(string_current_reference_o),
        .boost_peak_current_reference_o(boost_peak_current_reference_o),
        .string_drive_o(string_drive_o), .running_o(running_o));

    led_power_stage #(.HEADROOM(H)) stage (
        .clock_i(clock_i), .boost_switch_gate_i(boost_switch_gate_o),
        .optimiser_feedback_sink_i(optimiser_feedback_sink_o),
        .string_drive_i(string_drive_o),
        .boost_peak_current_reference_i(boost_peak_current_reference_o),
        .string_current_reference_i(string_current_reference_o), .sense_o(sense));

    // ------------------------------------------------------------
    // monitors: string gate pulses and boost switching intervals
    // ------------------------------------------------------------
    always @(posedge clock_i) begin
        if (string_gate_o === 1'b1) begin
            gate_len++;
        end else if (gate_len > 0) begin
            w_mon = (exp_q.size() > 0) ? exp_q.pop_front() : -1;
            `CHK("gate width", (w_mon < 0) ? -1 : ((w_mon < MIN) ? MIN : w_mon), gate_len)
            gate_len = 0;
        end
        if (boost_switch_gate_o === 1'b1) begin
            if (b_watch && b_low > 0) `CHK("boost off", OFF, b_low)
            b_low = 0;
            b_high++;
        end else begin
            if (b_watch && b_high > 0) `CHK("boost on", 1'b1, b_high <= (ref_model[1] + 15) / 16 + 5)
            b_high = 0;
            b_low++;
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #2;
    endtask

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        reg_w = '{write: 1'b1, addr: addr, data: data};
        step(1);
        reg_w = '{write: 1'b0, addr: ~addr, data: ~data};
        if (enable_i && addr == 8'h20) ref_model[0] = data;
        if (enable_i && addr == 8'h21) ref_model[1] = data;
        step(1);
    endtask

    task automatic check_refs();
        `CHK("string ref", 8'(ref_model[0]), string_current_reference_o)
        `CHK("boost ref", 8'(ref_model[1]), boost_peak_current_reference_o)
    endtask

    task automatic check_off();
        `CHK("string gate off", 1'b0, string_gate_o)
        `CHK("boost gate off", 1'b0, boost_switch_gate_o)
        `CHK("running off", 1'b0, running_o)
        `CHK("drive off", 8'h00, string_drive_o)
        `CHK("sink off", 8'h00, optimiser_feedback_sink_o)
    endtask

    task automatic start_run();
        int n;
        dimming_i = 1'b1;
        step(P + O - 4);
        `CHK("running early", 1'b0, running_o)
        `CHK("gate early", 1'b0, string_gate_o)
        dimming_i = 1'b0;
        n = P + O - 4;
        while (running_o !== 1'b1 && n < P + O + 20) begin
            step(1);
            n++;
        end
        `CHK("run start", P + O + 4, n)
        if (running_o !== 1'b1) print_verdict();
    endtask

    task automatic print_verdict();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(18));
        step(4);
        nrst_i = 1'b1;
        check_refs();
        check_off();
        write_reg(8'h20, 8'h11);
        step(3);
        check_refs();
        for (i = 0; i < 2; i++) begin
            enable_i = 1'b1;
            step(i == 0 ? P / 2 : P + O / 2);
            enable_i = 1'b0;
            step(4);
            check_off();
        end
        enable_i = 1'b1;
        start_run();
        write_reg(8'h20, 8'(8'h20 + $urandom % 200));
        write_reg(8'h21, 8'(8'h20 + $urandom % 200));
        write_reg(8'h40, 8'h00);
        step(1);
        check_refs();
        step(20);
        b_watch = 1;
        step(400);
        b_watch = 0;
        // three-cycle sense latency settles each loop into a fixed limit cycle
        lo_drv = 255;
        hi_drv = 0;
        lo_trim = 255;
        hi_trim = 0;
        repeat (12) begin
            step(1);
            if (int'(string_drive_o) < lo_drv) lo_drv = int'(string_drive_o);
            if (int'(string_drive_o) > hi_drv) hi_drv = int'(string_drive_o);
            if (int'(optimiser_feedback_sink_o) < lo_trim) lo_trim = int'(optimiser_feedback_sink_o);
            if (int'(optimiser_feedback_sink_o) > hi_trim) hi_trim = int'(optimiser_feedback_sink_o);
        end
        `CHK("drive low", ref_model[0] - 3, lo_drv)
        `CHK("drive high", ref_model[0] + 2, hi_drv)
        `CHK("sink low", H - 3, lo_trim)
        `CHK("sink high", H + 2, hi_trim)
        for (i = 0; i < 6; i++) begin
            w = (i % 2 == 0) ? 25 + $urandom % 25 : 60 + $urandom % 100;
            exp_q.push_back(w);
            dimming_i = 1'b1;
            step(w);
            dimming_i = 1'b0;
            step(2500 - w);
        end
        `CHK("pulses seen", 0, exp_q.size())
        over_temp_i = 1'b1;
        step(5);
        check_off();
        over_temp_i = 1'b0;
        start_run();
        check_refs();
        enable_i = 1'b0;
        ref_model = '{100, 100};
        step(4);
        check_refs();
        check_off();
        print_verdict();
    end
endmodule // led_string_boost_control_tb_top
